// ==== pkg/pmh_pkg.sv ====
// Purpose: shared constants and types for the high-resolution modulator auxiliary logic
// Assumes: one clock domain, sys_clk at 10 MHz
// Notes: event values carry a 14-bit coarse count above a 4-bit phase
package pmh_pkg;
  localparam int PMH_CNT_W = 14;
  localparam int PMH_PH_W = 4;
  localparam int PMH_EV_W = 18;
  localparam int PMH_CMP_W = 18;
  localparam int PMH_DIV_W = 8;
  localparam int PMH_ST_W = 12;
  localparam int PMH_LATENCY = 3;
  localparam logic [1:0] PMH_RES_16 = 2'h0;
  localparam logic [1:0] PMH_RES_8 = 2'h1;
  localparam logic [1:0] PMH_RES_4 = 2'h2;
  localparam logic [1:0] PMH_RES_2 = 2'h3;
  localparam logic [3:0] PMH_MASK_16 = 4'hf;
  localparam logic [3:0] PMH_MASK_8 = 4'he;
  localparam logic [3:0] PMH_MASK_4 = 4'hc;
  localparam logic [3:0] PMH_MASK_2 = 4'h8;
  localparam logic [2:0] PMH_SCL_X1 = 3'h0;
  localparam logic [2:0] PMH_SCL_X2 = 3'h1;
  localparam logic [2:0] PMH_SCL_X4 = 3'h2;
  localparam logic [2:0] PMH_SCL_X8 = 3'h3;
  localparam logic [2:0] PMH_SCL_D2 = 3'h5;
  localparam logic [2:0] PMH_SCL_D4 = 3'h6;
  localparam logic [2:0] PMH_SCL_D8 = 3'h7;
  localparam logic [PMH_CNT_W-1:0] PMH_CNT_RST = 14'h0000;
  localparam logic [PMH_DIV_W-1:0] PMH_DIV_RST = 8'h00;
  localparam logic [PMH_EV_W-1:0] PMH_EV_RST = 18'h00000;
  typedef enum logic [1:0] {PMH_FR_RUN, PMH_FR_WAIT, PMH_FR_STEP} pmh_frame_t;
endpackage : pmh_pkg

// ==== pkg/pmh_trip_if.sv ====
// Purpose: carries period timing into the overcurrent trip counter
// Assumes: all signals synchronous to sys_clk
// Notes: none
`timescale 1ns/10ps
interface pmh_trip_if;
  logic period_end;
  logic event2_hit;
  logic limit_in;
  logic enable;
  logic count_continuous;
  logic [7:0] max_count;
  logic clear;
  logic overcurrent_trip;
  logic [7:0] count;
  modport ctl (output period_end, event2_hit, limit_in, enable, count_continuous, max_count, clear,
               input overcurrent_trip, count);
  modport trip (input period_end, event2_hit, limit_in, enable, count_continuous, max_count, clear,
                output overcurrent_trip, count);
endinterface : pmh_trip_if

// ==== rtl/pmh_trip_counter.sv ====
// Purpose: counts sampled current-limit indications and latches the trip flag
// Assumes: period_end and event2_hit are single-cycle pulses
// Notes: a set on the same edge as a clear wins
`timescale 1ns/10ps
module pmh_trip_counter
  import pmh_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  pmh_trip_if.trip tif
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic seen;
  logic next_seen;
  logic flag;
  logic next_flag;
  logic hit;

  always_comb begin
    next_count = count;
    next_seen = seen;
    next_flag = flag;
    hit = tif.enable && tif.event2_hit && tif.limit_in; // see RL13
    if (tif.clear) begin
      next_count = 8'h00; // see RL22
      next_flag = 1'b0;
      next_seen = 1'b0;
    end
    if (hit) begin
      next_seen = 1'b1;
      if (count != 8'hff) begin
        next_count = (tif.clear ? 8'h00 : count) + 8'h01;
      end
    end
    if (tif.enable && tif.period_end && !hit) begin
      if (!tif.count_continuous && !seen) begin
        next_count = 8'h00; // see RL15
      end
      next_seen = 1'b0;
    end
    if (tif.enable && tif.period_end && hit) begin
      next_seen = 1'b0;
    end
    if (tif.enable && next_count >= tif.max_count && next_count != 8'h00) begin
      next_flag = 1'b1; // see RL14, RL16
    end
    if (!tif.enable) begin
      next_count = 8'h00;
      next_seen = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= 8'h00;
      seen <= 1'b0;
      flag <= 1'b0;
    end else begin
      count <= next_count;
      seen <= next_seen;
      flag <= next_flag;
    end
  end

  assign tif.overcurrent_trip = flag;
  assign tif.count = count;
endmodule : pmh_trip_counter

// ==== rtl/pmh_modulator_aux.sv ====
// Purpose: high-resolution edge placement, sampler triggers, period interrupt, update control, trip
// Assumes: sys_clk stands for the quarter_rate_control_clock; counter counts fast-clock units
// Notes: edges leave as coarse count plus phase for the fast-clock edge stage
// Notes on behaviour
// RL1: edges pick one of 16 equal phases per fast clock, 250 ps steps.
// RL2: resolution 00 all phases, 01 even, 10 multiples of four, 11 zero and eight.
// RL3: disable control drops phase, edges land on whole fast-clock boundaries.
// RL4: oversampling 00 triggers the error sampler once per period at trigger match.
// RL5: other oversampling settings trigger two, four or eight times per period.
// RL6: period interrupt divided to one per divide count plus one periods.
// RL7: divide settings 1 to 15 map to the listed divide counts.
// RL8: counter equal to sample trigger value issues a sampling request.
// RL9: compensator value is used a fixed latency after each sampling request.
// RL10: end-of-period update holds new compensator value until period end.
// RL11: single-frame enable advances the modulator one frame per step.
// RL12: compensator value scaled by times or divide two, four or eight.
// RL13: trip logic counts current-limit indications sampled at event-2 time.
// RL14: trip flag sets when the count reaches the 8-bit maximum; here it sets once the count reaches max_count.
// RL15: count-continuous 0 counts consecutive faulted cycles, resets on a clean one.
// RL16: count-continuous 1 accumulates without reset until the maximum.
// RL17: trip flag is offered to the processor as an interrupt source.
// RL18: while tripped, modulator outputs are forced inactive.
// RL19: current-limit source is one of comparators A to D by selection.
// RL20: phase placement only on events 2, 3, 4; low 4 bits phase.
// RL21: software programs the sample trigger as a quarter of the fast position.
// RL22: trip flag holds until cleared; clear also zeroes the counter.
// RL23: oversampling triggers spaced evenly, offset from the trigger position.
`timescale 1ns/10ps
module pmh_modulator_aux
  import pmh_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [13:0] period,
  input wire logic [11:0] sample_trigger,
  input wire logic [17:0] event2,
  input wire logic [17:0] event3,
  input wire logic [17:0] event4,
  input wire logic hires_disable,
  input wire logic [1:0] hires_resolution,
  input wire logic [1:0] oversample,
  input wire logic [3:0] int_divide,
  input wire logic update_end_of_period,
  input wire logic single_frame,
  input wire logic frame_step,
  input wire logic closed_loop,
  input wire logic [2:0] comp_scale,
  input wire logic [17:0] comp_value,
  input wire logic [3:0] comparators,
  input wire logic [1:0] limit_select,
  input wire logic trip_enable,
  input wire logic count_continuous,
  input wire logic [7:0] max_count,
  input wire logic trip_clear,
  input wire logic pwm_a_raw,
  input wire logic pwm_b_raw,
  output logic [13:0] counter,
  output logic sample_request,
  output logic period_irq,
  output logic [17:0] edge2,
  output logic [17:0] edge3,
  output logic [17:0] edge4,
  output logic pwm_a,
  output logic pwm_b,
  output logic overcurrent_trip,
  output logic [7:0] trip_count
);
  pmh_trip_if tif();

  logic [13:0] next_counter;
  pmh_frame_t frame;
  pmh_frame_t next_frame;
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic [2:0] os_idx;
  logic [2:0] next_os_idx;
  logic [PMH_LATENCY-1:0] lat;
  logic [PMH_LATENCY-1:0] next_lat;
  logic [17:0] pending;
  logic [17:0] next_pending;
  logic pend_valid;
  logic next_pend_valid;
  logic [17:0] active_comp;
  logic [17:0] next_active_comp;
  logic next_sample_request;
  logic next_period_irq;
  logic [17:0] next_edge2;
  logic [17:0] next_edge3;
  logic [17:0] next_edge4;
  logic next_pwm_a;
  logic next_pwm_b;

  logic advancing;
  logic period_end;
  logic [7:0] div_count;
  logic [3:0] ph_mask;
  logic [13:0] trig_pos;
  logic [13:0] os_step;
  logic [13:0] os_pos;
  logic [2:0] os_last;
  logic [17:0] scaled;
  logic [17:0] e2_src;
  logic [17:0] e3_src;

  // interrupt divide setting to divide count
  always_comb begin
    case (int_divide)
      4'h2: div_count = 8'h01;
      4'h3: div_count = 8'h03;
      4'h4: div_count = 8'h07;
      4'h5: div_count = 8'h0f;
      4'h6: div_count = 8'h1f;
      4'h7: div_count = 8'h2f;
      4'h8: div_count = 8'h3f;
      4'h9: div_count = 8'h4f;
      4'ha: div_count = 8'h5f;
      4'hb: div_count = 8'h7f;
      4'hc: div_count = 8'h9f;
      4'hd: div_count = 8'hbf;
      4'he: div_count = 8'hdf;
      4'hf: div_count = 8'hff;
      default: div_count = 8'h00;
    endcase // see RL7
  end

  always_comb begin
    case (hires_resolution)
      PMH_RES_8: ph_mask = PMH_MASK_8;
      PMH_RES_4: ph_mask = PMH_MASK_4;
      PMH_RES_2: ph_mask = PMH_MASK_2;
      default: ph_mask = PMH_MASK_16;
    endcase // see RL2
  end

  always_comb begin
    case (comp_scale)
      PMH_SCL_X2: scaled = {comp_value[16:0], 1'b0};
      PMH_SCL_X4: scaled = {comp_value[15:0], 2'h0};
      PMH_SCL_X8: scaled = {comp_value[14:0], 3'h0};
      PMH_SCL_D2: scaled = {1'b0, comp_value[17:1]};
      PMH_SCL_D4: scaled = {2'h0, comp_value[17:2]};
      PMH_SCL_D8: scaled = {3'h0, comp_value[17:3]};
      default: scaled = comp_value;
    endcase // see RL12
  end

  always_comb begin
    case (oversample)
      2'h1: os_last = 3'h1;
      2'h2: os_last = 3'h3;
      2'h3: os_last = 3'h7;
      default: os_last = 3'h0;
    endcase // see RL5
  end

  // trigger value is in control-clock units, four fast counts each
  assign trig_pos = {sample_trigger, 2'h0}; // see RL21
  assign os_step = (oversample == 2'h1) ? {1'b0, period[13:1]} :
                   (oversample == 2'h2) ? {2'h0, period[13:2]} :
                   {3'h0, period[13:3]};
  assign os_pos = 14'(trig_pos + 14'(os_step * 14'(os_idx))); // see RL23
  assign advancing = run && (frame != PMH_FR_WAIT);
  assign period_end = advancing && (counter >= period);
  assign e2_src = closed_loop ? active_comp : event2;
  assign e3_src = closed_loop ? 18'(active_comp + (event3 - event2)) : event3;

  always_comb begin
    next_counter = counter;
    next_frame = frame;
    next_div_cnt = div_cnt;
    next_os_idx = os_idx;
    next_lat = {lat[PMH_LATENCY-2:0], 1'b0};
    next_pending = pending;
    next_pend_valid = pend_valid;
    next_active_comp = active_comp;
    next_sample_request = 1'b0;
    next_period_irq = 1'b0;
    if (advancing) begin
      next_counter = period_end ? PMH_CNT_RST : 14'(counter + 14'h0004);
      if ((os_idx == 3'h0 && counter[13:2] == sample_trigger) ||
          (os_idx != 3'h0 && counter[13:2] == os_pos[13:2])) begin
        next_sample_request = 1'b1; // see RL4, RL8
        next_lat[0] = 1'b1;
        next_os_idx = (os_idx == os_last) ? 3'h0 : 3'(os_idx + 3'h1); // see RL5
      end
    end
    if (lat[PMH_LATENCY-1]) begin
      if (update_end_of_period) begin
        next_pending = scaled; // see RL10
        next_pend_valid = 1'b1;
      end else begin
        next_active_comp = scaled; // see RL9
      end
    end
    if (period_end) begin
      next_os_idx = 3'h0;
      if (pend_valid) begin
        next_active_comp = pending; // see RL10
        next_pend_valid = 1'b0;
      end
      if (div_cnt >= div_count) begin
        next_div_cnt = PMH_DIV_RST;
        next_period_irq = 1'b1; // see RL6
      end else begin
        next_div_cnt = 8'(div_cnt + 8'h01);
      end
    end
    if (!update_end_of_period) begin
      next_pend_valid = 1'b0;
    end
    // single-frame stepping: park at period end until a step pulse arrives
    case (frame)
      PMH_FR_RUN: begin
        if (single_frame && period_end) begin
          next_frame = PMH_FR_WAIT; // see RL11
        end
      end
      PMH_FR_WAIT: begin
        if (!single_frame) begin
          next_frame = PMH_FR_RUN;
        end else if (frame_step) begin
          next_frame = PMH_FR_STEP;
        end
      end
      PMH_FR_STEP: begin
        if (period_end) begin
          next_frame = single_frame ? PMH_FR_WAIT : PMH_FR_RUN;
        end
      end
      default: begin
        next_frame = PMH_FR_RUN;
      end
    endcase
  end

  always_comb begin
    next_edge2 = e2_src;
    next_edge3 = e3_src;
    next_edge4 = event4;
    if (hires_disable) begin
      next_edge2[3:0] = 4'h0; // see RL3
      next_edge3[3:0] = 4'h0;
      next_edge4[3:0] = 4'h0;
    end else begin
      next_edge2[3:0] = e2_src[3:0] & ph_mask; // see RL1, RL20
      next_edge3[3:0] = e3_src[3:0] & ph_mask;
      next_edge4[3:0] = event4[3:0] & ph_mask;
    end
    next_pwm_a = pwm_a_raw && !tif.overcurrent_trip; // see RL18
    next_pwm_b = pwm_b_raw && !tif.overcurrent_trip;
  end

  assign tif.period_end = period_end;
  assign tif.event2_hit = advancing && (counter[13:2] == edge2[17:6]); // see RL13
  assign tif.limit_in = comparators[limit_select]; // see RL19
  assign tif.enable = trip_enable;
  assign tif.count_continuous = count_continuous;
  assign tif.max_count = max_count;
  assign tif.clear = trip_clear;

  // trip flag feeds back into the output gating above
  pmh_trip_counter u_trip (
    .sys_clk(sys_clk),
    .rst(rst),
    .tif(tif)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      counter <= PMH_CNT_RST;
      frame <= PMH_FR_RUN;
      div_cnt <= PMH_DIV_RST;
      os_idx <= 3'h0;
      lat <= '0;
      pending <= PMH_EV_RST;
      pend_valid <= 1'b0;
      active_comp <= PMH_EV_RST;
      sample_request <= 1'b0;
      period_irq <= 1'b0;
      edge2 <= PMH_EV_RST;
      edge3 <= PMH_EV_RST;
      edge4 <= PMH_EV_RST;
      pwm_a <= 1'b0;
      pwm_b <= 1'b0;
    end else begin
      counter <= next_counter;
      frame <= next_frame;
      div_cnt <= next_div_cnt;
      os_idx <= next_os_idx;
      lat <= next_lat;
      pending <= next_pending;
      pend_valid <= next_pend_valid;
      active_comp <= next_active_comp;
      sample_request <= next_sample_request;
      period_irq <= next_period_irq;
      edge2 <= next_edge2;
      edge3 <= next_edge3;
      edge4 <= next_edge4;
      pwm_a <= next_pwm_a;
      pwm_b <= next_pwm_b;
    end
  end

  assign overcurrent_trip = tif.overcurrent_trip; // see RL17
  assign trip_count = tif.count;
endmodule : pmh_modulator_aux

// ==== sim/pmh_modulator_aux_asserts.sv ====
// Purpose: port checks for pmh_modulator_aux
// Assumes: period of at least 8
// Notes: bound at the foot
`timescale 1ns/10ps
module pmh_modulator_aux_asserts
  import pmh_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [13:0] period,
  input wire logic [11:0] sample_trigger,
  input wire logic [17:0] event4,
  input wire logic hires_disable,
  input wire logic [1:0] hires_resolution,
  input wire logic [1:0] oversample,
  input wire logic single_frame,
  input wire logic trip_enable,
  input wire logic trip_clear,
  input wire logic [13:0] counter,
  input wire logic sample_request,
  input wire logic period_irq,
  input wire logic [17:0] edge4,
  input wire logic pwm_a,
  input wire logic pwm_b,
  input wire logic overcurrent_trip,
  input wire logic [7:0] trip_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic up;
  logic [3:0] msk;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      up <= 1'b0;
    end else begin
      up <= 1'b1;
    end
  end
  assign msk = 4'hf << hires_resolution;
  sequence wrap_s;
    counter == PMH_CNT_RST;
  endsequence
  period_wrap_a: assert property (run && !single_frame && counter >= period |=> wrap_s)
    else $error("counter did not wrap");
  counter_step_a: assert property (up && run && !single_frame && counter < period
    |=> counter == $past(counter) + 14'h4)
    else $error("counter step wrong");
  sample_match_a: assert property (run && !single_frame && oversample == 2'h0
    && counter[13:2] == sample_trigger |=> sample_request)
    else $error("sample request missing");
  irq_pulse_a: assert property (period_irq |=> !period_irq)
    else $error("period irq too long");
  phase_off_a: assert property (up && $past(hires_disable) |-> edge4[3:0] == 4'h0)
    else $error("phase not dropped");
  phase_mask_a: assert property (up && !$past(hires_disable)
    |-> edge4 == ($past(event4) & {14'h3fff, $past(msk)}))
    else $error("edge4 phase mask wrong");
  trip_hold_a: assert property (overcurrent_trip && !trip_clear |=> overcurrent_trip)
    else $error("trip flag dropped");
  trip_off_a: assert property (overcurrent_trip && $past(overcurrent_trip) |-> !pwm_a && !pwm_b)
    else $error("outputs active while tripped");
  trip_clear_a: assert property (trip_clear && !trip_enable
    |=> trip_count == 8'h0 && !overcurrent_trip)
    else $error("clear did not reset trip");
endmodule : pmh_modulator_aux_asserts
bind pmh_modulator_aux pmh_modulator_aux_asserts u_chk (.sys_clk, .rst, .run, .period, .sample_trigger,
  .event4, .hires_disable, .hires_resolution, .oversample, .single_frame, .trip_enable, .trip_clear,
  .counter, .sample_request, .period_irq, .edge4, .pwm_a, .pwm_b, .overcurrent_trip, .trip_count);

// ==== sim/pmh_loop_model.sv ====
// Purpose: error sampler and compensator stand-in
// Assumes: answer DELAY cycles after a request
// Notes: result register holds between answers
`timescale 1ns/10ps
module pmh_loop_model #(parameter int DELAY = 2) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sample_request,
  input wire logic [17:0] target,
  output logic [17:0] comp_value
);
  logic [7:0] wait_cnt;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 8'h0;
      comp_value <= 18'h0;
    end else if (sample_request) begin
      wait_cnt <= 8'(DELAY);
    end else if (wait_cnt == 8'h1) begin
      wait_cnt <= 8'h0;
      comp_value <= target;
    end else if (wait_cnt != 8'h0) begin
      wait_cnt <= wait_cnt - 8'h1;
    end
  end
endmodule : pmh_loop_model

// ==== sim/tb_pmh_modulator_aux.sv ====
// Purpose: self-checking bench for pmh_modulator_aux
// Assumes: event2 sample point mid-period
// Notes: loop model answers the edge after it sees a request, inside the fixed latency
`timescale 1ns/10ps
module tb_pmh_modulator_aux;
  logic sys_clk = 1'b0, rst = 1'b1, run = 1'b1, hires_disable = 1'b0, update_end_of_period = 1'b0;
  logic single_frame = 1'b0, frame_step = 1'b0, closed_loop = 1'b0, trip_enable = 1'b0;
  logic count_continuous = 1'b0, trip_clear = 1'b0, pwm_a_raw = 1'b1, pwm_b_raw = 1'b1;
  logic sample_request, period_irq, pwm_a, pwm_b, overcurrent_trip;
  logic [13:0] period = 14'h8, counter;
  logic [11:0] sample_trigger = 12'h0;
  logic [17:0] event2 = 18'h0, event3 = 18'h0, event4 = 18'h0, target = 18'h800;
  logic [17:0] comp_value, edge2, edge3, edge4;
  logic [1:0] hires_resolution = 2'h0, oversample = 2'h0, limit_select = 2'h0;
  logic [3:0] int_divide = 4'h1, comparators = 4'h0;
  logic [2:0] comp_scale = 3'h0;
  logic [7:0] max_count = 8'h3, trip_count;
  int fail_count = 0, checks = 0;
  always #50 sys_clk = ~sys_clk;
  pmh_modulator_aux u_dut (.sys_clk, .rst, .run, .period, .sample_trigger, .event2, .event3, .event4,
    .hires_disable, .hires_resolution, .oversample, .int_divide, .update_end_of_period, .single_frame,
    .frame_step, .closed_loop, .comp_scale, .comp_value, .comparators, .limit_select, .trip_enable,
    .count_continuous, .max_count, .trip_clear, .pwm_a_raw, .pwm_b_raw, .counter, .sample_request,
    .period_irq, .edge2, .edge3, .edge4, .pwm_a, .pwm_b, .overcurrent_trip, .trip_count);
  pmh_loop_model #(.DELAY(1)) u_loop (.sys_clk, .rst, .sample_request, .target, .comp_value);
  task automatic finish_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic tally(input int n, output int sr, output int ir);
    sr = 0;
    ir = 0;
    repeat (n) begin
      cyc(1);
      sr += int'(sample_request === 1'b1);
      ir += int'(period_irq === 1'b1);
    end
  endtask : tally
  task automatic periods(input int n);
    int k;
    k = 0;
    while (n > 0) begin
      cyc(1);
      if (period_irq === 1'b1) n--;
      if (++k > 5000) begin
        fail_count++;
        finish_test();
      end
    end
  endtask : periods
  task automatic wait_edge2(input logic [17:0] v);
    int k;
    k = 0;
    while (edge2 !== v && k < 200) begin
      cyc(1);
      k++;
    end
    cmp(edge2, v);
    if (k == 200) finish_test();
  endtask : wait_edge2
  task automatic wait_req;
    int k;
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (sample_request !== 1'b1 && k < 100);
    if (sample_request !== 1'b1) begin
      fail_count++;
      finish_test();
    end
  endtask : wait_req
  task automatic clear_trip;
    @(posedge sys_clk);
    comparators <= 4'h0;
    trip_enable <= 1'b0;
    trip_clear <= 1'b1;
    @(posedge sys_clk) trip_clear <= 1'b0;
    trip_enable <= 1'b1;
    cyc(1);
  endtask : clear_trip
  task automatic t_div;
    int sr, ir;
    int dc [16] = '{0, 0, 1, 3, 7, 15, 31, 47, 63, 79, 95, 127, 159, 191, 223, 255};
    for (int s = 0; s < 16; s++) begin
      @(posedge sys_clk) int_divide <= 4'(s);
      cyc(3 * (dc[s] + 1));
      tally(6 * (dc[s] + 1), sr, ir);
      cmp(18'(ir), 18'h2);
      cmp(18'(sr), 18'(2 * (dc[s] + 1)));
    end
    @(posedge sys_clk) int_divide <= 4'h1;
  endtask : t_div
  task automatic t_over;
    int sr, ir;
    @(posedge sys_clk);
    period <= 14'h80;
    sample_trigger <= 12'h2;
    for (int o = 0; o < 4; o++) begin
      @(posedge sys_clk) oversample <= 2'(o);
      cyc(33);
      tally(66, sr, ir);
      cmp(18'(sr), 18'(2 << o));
      cmp(18'(ir), 18'h2);
    end
    @(posedge sys_clk) oversample <= 2'h0;
  endtask : t_over
  task automatic t_hires;
    logic [17:0] k;
    @(posedge sys_clk);
    event2 <= 18'h2a5b7;
    event3 <= 18'h2a6cf;
    event4 <= 18'h3ff9d;
    for (int r = 0; r < 5; r++) begin
      @(posedge sys_clk);
      hires_resolution <= 2'(r);
      hires_disable <= (r == 4);
      k = {14'h3fff, (r == 4) ? 4'h0 : 4'(4'hf << r)};
      cyc(3);
      cmp(edge2, event2 & k);
      cmp(edge3, event3 & k);
      cmp(edge4, event4 & k);
    end
    @(posedge sys_clk);
    hires_disable <= 1'b0;
    hires_resolution <= 2'h0;
  endtask : t_hires
  task automatic t_scale;
    logic [17:0] e [8] = '{18'h800, 18'h1000, 18'h2000, 18'h4000, 18'h800, 18'h400, 18'h200, 18'h100};
    @(posedge sys_clk) closed_loop <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      @(posedge sys_clk) comp_scale <= 3'(c);
      wait_edge2(e[c]);
    end
    @(posedge sys_clk) comp_scale <= 3'h0;
    wait_edge2(18'h800);
    // new result must reach edge2 exactly four edges after the request is seen
    @(posedge sys_clk) target <= 18'ha00;
    wait_req();
    cyc(3);
    cmp(edge2, 18'h800);
    cyc(1);
    cmp(edge2, 18'ha00);
    @(posedge sys_clk);
    update_end_of_period <= 1'b1;
    target <= 18'h900;
    wait_edge2(18'h900);
    cmp(18'(counter < 14'hc), 18'h1);
    @(posedge sys_clk);
    closed_loop <= 1'b0;
    update_end_of_period <= 1'b0;
  endtask : t_scale
  task automatic t_trip;
    @(posedge sys_clk);
    event2 <= 18'h00400;
    trip_enable <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      limit_select <= 2'(s);
      comparators <= ~(4'h1 << s);
      periods(5);
      cmp(18'(overcurrent_trip), 18'h0);
      cmp(18'(pwm_a), 18'h1);
      @(posedge sys_clk) comparators <= 4'h1 << s;
      periods(5);
      cmp(18'(overcurrent_trip), 18'h1);
      cmp(18'({pwm_a, pwm_b}), 18'h0);
      clear_trip();
      cmp(18'(trip_count), 18'h0);
      cmp(18'(overcurrent_trip), 18'h0);
    end
  endtask : t_trip
  task automatic t_consec;
    bit p [5] = '{1, 1, 0, 1, 1};
    for (int c = 0; c < 2; c++) begin
      clear_trip();
      @(posedge sys_clk);
      count_continuous <= c[0];
      limit_select <= 2'h0;
      foreach (p[i]) begin
        @(posedge sys_clk) comparators <= {3'h0, p[i]};
        periods(1);
      end
      @(posedge sys_clk) comparators <= 4'h0;
      periods(2);
      cmp(18'(overcurrent_trip), 18'(c));
    end
  endtask : t_consec
  task automatic t_frame;
    logic [13:0] c;
    @(posedge sys_clk) single_frame <= 1'b1;
    cyc(80);
    c = counter;
    cyc(10);
    cmp(18'(counter), 18'(c));
    @(posedge sys_clk) frame_step <= 1'b1;
    @(posedge sys_clk) frame_step <= 1'b0;
    cyc(2);
    cmp(18'(counter != c), 18'h1);
    @(posedge sys_clk) single_frame <= 1'b0;
  endtask : t_frame
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(2);
    t_div();
    t_over();
    t_hires();
    t_scale();
    t_trip();
    t_consec();
    t_frame();
    finish_test();
  end
endmodule : tb_pmh_modulator_aux
